// ### fts_fifo.sv
// Purpose: Parameterised flip-flop FIFO with valid and ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   Full and empty come straight from the occupancy count.
`timescale 1ns/10ps
module fts_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
    } fts_fifo_st_s;

    fts_fifo_st_s q;
    fts_fifo_st_s d;
    logic         push;
    logic         pop;

    // Flags from the count
    assign in_ready  = q.cnt != (AW+1)'(DEPTH);
    assign out_valid = q.cnt != '0;
    assign out_data  = q.mem[q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and storage update
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp        = q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = q.rp + 1'b1;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : fts_fifo

// ### fts_master.sv
// Purpose: Bus master model facing the SRAM cycle control.
// Assumes: Called one cycle at a time, just after the rising edge.
// Notes:   A released data bus shows the inverse of its last level.
`timescale 1ns/10ps
module fts_master (
    // Clock
    input  wire logic        clk,
    // Cycle control
    output logic             clock_gate_n,
    output logic             chip_select_a_n,
    output logic             chip_select_b,
    output logic             chip_select_c_n,
    output logic             advance_not_load,
    output logic             write_n,
    output logic [3:0]       byte_lane_select_n,
    output logic [5:0]       addr,
    // Data pins
    output logic [31:0]      dq_in,
    output logic [3:0]       parity_pins_in,
    input  wire logic [31:0] dq_out,
    input  wire logic [3:0]  parity_pins_out,
    input  wire logic        dq_oe
);
    logic        drv;
    logic [35:0] drv_w;
    logic [35:0] last_w = 36'h0;

    // Wire level from both drivers
    always_comb begin
        if (dq_oe)
            {parity_pins_in, dq_in} = {parity_pins_out, dq_out};
        else if (drv)
            {parity_pins_in, dq_in} = drv_w;
        else
            {parity_pins_in, dq_in} = ~last_w;
    end

    // Last bus level, so a released bus never holds it
    always @(posedge clk) last_w <= {parity_pins_in, dq_in};

    // Idle bus at time zero
    initial begin
        clock_gate_n = 1'h0;
        {chip_select_a_n, chip_select_b, chip_select_c_n} = 3'h5;
        advance_not_load = 1'h0;
        write_n = 1'h1;
        byte_lane_select_n = 4'hf;
        addr = 6'h00;
        drv = 1'h0;
        drv_w = 36'h0;
    end

    // One bus cycle: present, let the edge pass
    task automatic cyc(input logic g, input logic l, input logic w, input logic [5:0] a,
                       input logic [3:0] bl, input logic [2:0] cs, input logic de,
                       input logic [35:0] dd);
        clock_gate_n = g;
        advance_not_load = l;
        write_n = w;
        addr = a;
        byte_lane_select_n = bl;
        {chip_select_a_n, chip_select_b, chip_select_c_n} = cs;
        drv = de;
        drv_w = dd;
        @(posedge clk);
        #1;
    endtask : cyc
endmodule : fts_master

// ### fts_pkg.sv
// Purpose: Shared constants and types for the flow-through SRAM cycle control.
// Assumes: Four byte lanes of eight data bits and one parity bit each.
// Notes:   Array depth is kept small; the storage is built from flip-flops.
package fts_pkg;
    localparam int ADDR_W    = 6;             // Word address width
    localparam int LANES     = 4;             // Byte lanes
    localparam int LANE_W    = 9;             // Eight data bits plus parity
    localparam int WORD_W    = LANES * LANE_W;
    localparam int BURST_W   = 2;             // Low address bits that burst
    localparam int SYNC_N    = 3;             // Sleep synchroniser stages
    localparam int FIFO_DEP  = 16;            // Write commit buffer depth
    localparam logic [LANES-1:0] LANES_OFF = 4'hf;  // No lane selected
    localparam logic [BURST_W-1:0] CNT_RST = 2'h0;

    // Access kind held through a burst
    typedef enum logic [2:0] {
        FTS_IDLE  = 3'b001,
        FTS_READ  = 3'b010,
        FTS_WRITE = 3'b100
    } fts_mode_e;

    // One committed write on its way to the array
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  lanes_n;
        logic [WORD_W-1:0] word;
    } fts_wr_s;

    localparam int WR_W = $bits(fts_wr_s);
endpackage : fts_pkg

// ### fts_sram_ctl.sv
// Purpose: Cycle control and flip-flop array of a flow-through burst SRAM.
// Assumes: All pins except sleep_request and output_enable_n are synchronous to clk.
// Notes:   dq_oe is gated by output_enable_n without any clocking.
`timescale 1ns/10ps
module fts_sram_ctl (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    // Cycle control
    input  wire logic                        clock_gate_n,
    input  wire logic                        chip_select_a_n,
    input  wire logic                        chip_select_b,
    input  wire logic                        chip_select_c_n,
    input  wire logic                        advance_not_load,
    input  wire logic                        write_n,
    input  wire logic [fts_pkg::LANES-1:0]   byte_lane_select_n,
    input  wire logic                        burst_order,
    input  wire logic                        sleep_request,
    input  wire logic                        output_enable_n,
    input  wire logic [fts_pkg::ADDR_W-1:0]  addr,
    // Data pins split into in, out and enable
    input  wire logic [31:0]                 dq_in,
    input  wire logic [fts_pkg::LANES-1:0]   parity_pins_in,
    output logic [31:0]                      dq_out,
    output logic [fts_pkg::LANES-1:0]        parity_pins_out,
    output logic                             dq_oe,
    // Commit buffer status
    output logic                             write_ready
);
    localparam int DEPTH = 1 << fts_pkg::ADDR_W;

    typedef struct packed {
        logic [DEPTH-1:0][fts_pkg::WORD_W-1:0] mem;
        fts_pkg::fts_mode_e                    mode;
        logic [fts_pkg::ADDR_W-1:0]            base;
        logic [fts_pkg::BURST_W-1:0]           cnt;
        logic                                  wr_pend;
        logic [fts_pkg::ADDR_W-1:0]            wr_addr;
        logic [fts_pkg::LANES-1:0]             wr_lanes;
        logic                                  drive;
        logic [fts_pkg::WORD_W-1:0]            rd_word;
        logic [fts_pkg::SYNC_N-1:0]            sync;
        logic                                  sleep;
        logic                                  rdy;
    } fts_st_s;

    fts_st_s                    q;
    fts_st_s                    d;
    logic                       push_valid;
    fts_pkg::fts_wr_s           push_data;
    logic                       fifo_ready;
    logic                       head_valid;
    fts_pkg::fts_wr_s           head;
    logic                       selected;
    logic                       active;
    logic [fts_pkg::ADDR_W-1:0] acc_addr;

    // Lane-masked merge of new data into a stored word
    function automatic logic [fts_pkg::WORD_W-1:0] merge(
        input logic [fts_pkg::WORD_W-1:0] old_w,
        input logic [fts_pkg::WORD_W-1:0] new_w,
        input logic [fts_pkg::LANES-1:0]  lanes_n
    );
        logic [fts_pkg::WORD_W-1:0] r;
        r = old_w;
        for (int i = 0; i < fts_pkg::LANES; i++) begin
            if (!lanes_n[i]) begin
                r[i*fts_pkg::LANE_W +: fts_pkg::LANE_W] =
                    new_w[i*fts_pkg::LANE_W +: fts_pkg::LANE_W];
            end
        end
        return r;
    endfunction : merge

    // Burst address from base and counter, linear or interleaved
    function automatic logic [fts_pkg::ADDR_W-1:0] burst_addr(
        input logic [fts_pkg::ADDR_W-1:0]  b,
        input logic [fts_pkg::BURST_W-1:0] c,
        input logic                        ilv
    );
        logic [fts_pkg::BURST_W-1:0] lo;
        lo = ilv ? (b[fts_pkg::BURST_W-1:0] ^ c) : (b[fts_pkg::BURST_W-1:0] + c);
        return {b[fts_pkg::ADDR_W-1:fts_pkg::BURST_W], lo};
    endfunction : burst_addr

    // Pin lanes gathered into one stored word, one lane per pass
    logic [fts_pkg::WORD_W-1:0] pin_word;
    generate
        for (genvar g = 0; g < fts_pkg::LANES; g++) begin : g_lane
            assign pin_word[g*fts_pkg::LANE_W +: fts_pkg::LANE_W] =
                {parity_pins_in[g], dq_in[g*8 +: 8]};
            assign dq_out[g*8 +: 8]   = q.rd_word[g*fts_pkg::LANE_W +: 8];
            assign parity_pins_out[g] = q.rd_word[g*fts_pkg::LANE_W + 8];
        end
    endgenerate

    // Drivers gated by the unclocked enable
    assign dq_oe       = q.drive && !output_enable_n;
    assign write_ready = q.rdy;
    assign selected    = !chip_select_a_n && chip_select_b && !chip_select_c_n;
    assign active      = !clock_gate_n && !q.sleep;

    // Next state of the whole cycle controller
    always_comb begin
        d          = q;
        push_valid = 1'b0;
        push_data  = '0;
        acc_addr   = addr;
        d.sync     = {q.sync[fts_pkg::SYNC_N-2:0], sleep_request};
        if (q.sync[2] == q.sync[1]) begin
            d.sleep = q.sync[2];
        end
        d.rdy = fifo_ready;
        // Drain one committed write per cycle outside sleep
        if (head_valid && !q.sleep) begin
            d.mem[head.addr] = merge(q.mem[head.addr], head.word, head.lanes_n);
        end
        if (q.sleep) begin
            d.mode    = fts_pkg::FTS_IDLE;
            d.drive   = 1'b0;
            d.wr_pend = 1'b0;
        end else if (active) begin
            // Data phase of the previous write
            d.wr_pend = 1'b0;
            if (q.wr_pend && (q.wr_lanes != fts_pkg::LANES_OFF)) begin
                push_valid        = 1'b1;
                push_data.addr    = q.wr_addr;
                push_data.lanes_n = q.wr_lanes;
                push_data.word    = pin_word;
            end
            // Command phase
            if (advance_not_load) begin
                if (q.mode != fts_pkg::FTS_IDLE) begin
                    d.cnt = q.cnt + 1'b1;
                end
                acc_addr = burst_addr(q.base, d.cnt, burst_order);
            end else if (selected) begin
                d.mode = write_n ? fts_pkg::FTS_READ : fts_pkg::FTS_WRITE;
                d.base = addr;
                d.cnt  = fts_pkg::CNT_RST;
            end else begin
                d.mode = fts_pkg::FTS_IDLE;
            end
            // Access at the chosen address
            d.drive = 1'b0;
            case (d.mode)
                fts_pkg::FTS_READ: begin
                    d.drive   = 1'b1;
                    d.rd_word = q.mem[acc_addr];
                    if (head_valid && head.addr == acc_addr) begin
                        d.rd_word = merge(d.rd_word, head.word, head.lanes_n);
                    end
                    if (push_valid && push_data.addr == acc_addr) begin
                        d.rd_word = merge(d.rd_word, push_data.word, push_data.lanes_n);
                    end
                end
                fts_pkg::FTS_WRITE: begin
                    d.wr_pend  = 1'b1;
                    d.wr_addr  = acc_addr;
                    d.wr_lanes = byte_lane_select_n;
                end
                fts_pkg::FTS_IDLE: begin
                    d.drive = 1'b0;
                end
                default: begin
                    d.mode = fts_pkg::FTS_IDLE;
                end
            endcase
        end
    end

    // State register, deselected from reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q      <= '0;
            q.mode <= fts_pkg::FTS_IDLE;
        end else begin
            q <= d;
        end
    end

    // Write commit buffer, stalled while asleep
    fts_fifo #(
        .W     (fts_pkg::WR_W),
        .DEPTH (fts_pkg::FIFO_DEP)
    ) u_commit (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (push_valid),
        .in_ready  (fifo_ready),
        .in_data   (push_data),
        .out_valid (head_valid),
        .out_ready (!q.sleep),
        .out_data  (head)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_stall_holds;
        clock_gate_n && !q.sleep |=> $stable(q.drive) && $stable(q.cnt) && $stable(q.base);
    endproperty
    a_stall_holds: assert property (p_stall_holds) else $error("stall changed state");

    property p_write_floats;
        active && !advance_not_load && selected && !write_n |=> !dq_oe;
    endproperty
    a_write_floats: assert property (p_write_floats) else $error("pins driven in write");

    property p_oe_direct;
        q.mode == fts_pkg::FTS_READ && !output_enable_n |-> dq_oe;
    endproperty
    a_oe_direct: assert property (p_oe_direct) else $error("read not driven");

    property p_reset_float;
        $rose(rst_b) |-> !dq_oe && q.mode == fts_pkg::FTS_IDLE;
    endproperty
    a_reset_float: assert property (p_reset_float) else $error("not idle after reset");

    property p_oe_high_float;
        output_enable_n |-> !dq_oe;
    endproperty
    a_oe_high_float: assert property (p_oe_high_float) else $error("enable high drove");

    property p_abort_no_push;
        active && q.wr_pend && q.wr_lanes == fts_pkg::LANES_OFF |-> !push_valid;
    endproperty
    a_abort_no_push: assert property (p_abort_no_push) else $error("abort stored data");

    property p_write_commits;
        active && q.wr_pend && q.wr_lanes != fts_pkg::LANES_OFF |-> push_valid
            && push_data.lanes_n == q.wr_lanes && push_data.addr == q.wr_addr;
    endproperty
    a_write_commits: assert property (p_write_commits) else $error("write lost");

    property p_deselect;
        active && !advance_not_load && !selected ##1 active && advance_not_load |=> !q.drive;
    endproperty
    a_deselect: assert property (p_deselect) else $error("deselect drove pins");

    property p_burst_count;
        active && advance_not_load && q.mode == fts_pkg::FTS_READ
            |=> q.cnt == $past(q.cnt) + 2'h1 && q.mode == fts_pkg::FTS_READ && q.drive;
    endproperty
    a_burst_count: assert property (p_burst_count) else $error("burst did not advance");

    property p_ilv_order;
        active && advance_not_load && burst_order && q.mode == fts_pkg::FTS_WRITE
            |=> q.wr_addr[1:0] == (q.base[1:0] ^ q.cnt);
    endproperty
    a_ilv_order: assert property (p_ilv_order) else $error("interleave order wrong");
endmodule : fts_sram_ctl

// ### fts_sram_ctl_test.sv
// Purpose: Self-checking bench for the flow-through SRAM cycle control.
// Assumes: Commands go through the master model one cycle at a time.
// Notes:   Expected words are kept as parity above data, per address.
`timescale 1ns/10ps
module fts_sram_ctl_test;
    localparam logic [2:0] SEL = 3'h2; // All three selects active
    logic        clk = 1'h0, rst_b = 1'h0, oe_n = 1'h0, bo = 1'h0, pd = 1'h0;
    logic        gn, csa, csb, csc, anl, wn, dq_oe, wready;
    logic        sl = 1'h0; // Sleep request into the synchroniser
    logic [3:0]  ln, pin, pout;
    logic [5:0]  a, st;
    logic [31:0] din, dout;
    logic [35:0] mem [64];
    logic [35:0] pw;
    logic [1:0]  md = 2'h0, k; // Mode 0 idle, 1 read, 2 write
    int          n_fail = 0, n_tests = 0;

    always #4 clk = ~clk;

    fts_master fts_master_inst (.clk(clk), .clock_gate_n(gn), .chip_select_a_n(csa),
        .chip_select_b(csb), .chip_select_c_n(csc), .advance_not_load(anl), .write_n(wn),
        .byte_lane_select_n(ln), .addr(a), .dq_in(din), .parity_pins_in(pin),
        .dq_out(dout), .parity_pins_out(pout), .dq_oe(dq_oe));
    fts_sram_ctl fts_sram_ctl_inst (.clk(clk), .rst_b(rst_b), .clock_gate_n(gn),
        .chip_select_a_n(csa), .chip_select_b(csb), .chip_select_c_n(csc),
        .advance_not_load(anl), .write_n(wn), .byte_lane_select_n(ln), .burst_order(bo),
        .sleep_request(sl), .output_enable_n(oe_n), .addr(a), .dq_in(din),
        .parity_pins_in(pin), .dq_out(dout), .parity_pins_out(pout), .dq_oe(dq_oe),
        .write_ready(wready));

    task automatic chk(input logic [35:0] g, input logic [35:0] e, input string s);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, s, g, e);
        end
    endtask : chk

    task automatic chk_b(input logic g, input logic e, input string s);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: %s got %b", $time, s, g);
        end
    endtask : chk_b

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    // Lane merge of a byte write
    function automatic logic [35:0] mrg(input logic [35:0] o, input logic [35:0] n,
                                        input logic [3:0] bl);
        logic [35:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (!bl[i]) begin
                r[8*i +: 8] = n[8*i +: 8];
                r[32+i] = n[32+i];
            end
        end
        return r;
    endfunction : mrg

    // Current burst address
    function automatic logic [5:0] cur();
        return {st[5:2], bo ? st[1:0] ^ k : st[1:0] + k};
    endfunction : cur

    // One command with last write's data; checks the pins after the edge
    task automatic go(input logic l, input logic w, input logic [5:0] ad, input logic [3:0] bl,
                      input logic [2:0] cs, input logic [35:0] wd);
        logic        de;
        logic [35:0] dd;
        de = pd;
        dd = pw;
        if (!l) begin
            md = (cs != SEL) ? 2'h0 : (w ? 2'h1 : 2'h2);
            st = ad;
            k = 2'h0;
        end else
            k = k + 2'h1;
        pd = (md == 2'h2);
        pw = wd;
        if (pd)
            mem[cur()] = mrg(mem[cur()], wd, bl);
        fts_master_inst.cyc(1'h0, l, w, ad, bl, cs, de, dd);
        if (md == 2'h1) begin
            chk({pout, dout}, mem[cur()], "read word");
            chk_b(dq_oe, !oe_n, "read drive");
        end else
            chk_b(dq_oe, 1'h0, "float");
    endtask : go

    task automatic t_rw;
        logic [3:0] pat [8] = '{4'h0, 4'hf, 4'he, 4'hd, 4'hb, 4'h7, 4'ha, 4'h5};
        for (int i = 0; i < 8; i++) begin
            go(1'h0, 1'h0, 6'h05, pat[i], SEL, {9{4'(i + 1)}});
            go(1'h0, 1'h1, 6'h05, 4'hf, SEL, 36'h0);
        end
        $display("t_rw done");
    endtask : t_rw

    task automatic t_oe;
        go(1'h0, 1'h1, 6'h05, 4'hf, SEL, 36'h0);
        #1 oe_n = 1'h1;
        #1 chk_b(dq_oe, 1'h0, "oe off");
        oe_n = 1'h0;
        #1 chk_b(dq_oe, 1'h1, "oe on");
        @(posedge clk);
        #1;
        go(1'h0, 1'h1, 6'h05, 4'hf, 3'h6, 36'h0);
        go(1'h0, 1'h1, 6'h05, 4'hf, 3'h0, 36'h0);
        go(1'h0, 1'h1, 6'h05, 4'hf, 3'h3, 36'h0);
        go(1'h1, 1'h1, 6'h05, 4'hf, SEL, 36'h0);
        $display("t_oe done");
    endtask : t_oe

    task automatic t_burst;
        go(1'h0, 1'h0, 6'h08, 4'h0, SEL, 36'h1_2345_6789);
        for (int i = 1; i < 4; i++)
            go(1'h1, 1'h1, 6'h3f, 4'h0, 3'h5, 36'h1_2345_6789 + 36'(i));
        for (int b = 0; b < 2; b++) begin
            bo = b[0];
            for (int s = 8; s < 12; s++) begin
                go(1'h0, 1'h1, 6'(s), 4'hf, SEL, 36'h0);
                fts_master_inst.cyc(1'h1, 1'h0, 1'h0, 6'h3f, 4'h0, SEL, 1'h0, 36'h0);
                chk({pout, dout}, mem[cur()], "stall hold");
                for (int j = 0; j < 4; j++)
                    go(1'h1, 1'h0, 6'h3f, 4'h0, 3'h6, 36'h0);
            end
        end
        // Interleaved write burst, read back in the same order
        go(1'h0, 1'h0, 6'h0d, 4'h0, SEL, 36'h0_0f0f_0f0f);
        for (int i = 1; i < 4; i++)
            go(1'h1, 1'h1, 6'h3f, 4'h0, 3'h5, 36'h0_0f0f_0f0f + 36'(i));
        go(1'h0, 1'h1, 6'h0d, 4'hf, SEL, 36'h0);
        for (int i = 1; i < 4; i++)
            go(1'h1, 1'h0, 6'h3f, 4'h0, 3'h6, 36'h0);
        $display("t_burst done");
    endtask : t_burst

    // Write through the commit buffer, sleep through ignored commands, wake, read back
    task automatic t_sleep;
        go(1'h0, 1'h0, 6'h20, 4'h0, SEL, 36'h9_8765_4321);
        go(1'h0, 1'h1, 6'h20, 4'hf, SEL, 36'h0);
        chk_b(wready, 1'h1, "commit room");
        go(1'h0, 1'h1, 6'h20, 4'hf, 3'h5, 36'h0);
        sl = 1'h1;
        repeat (5)
            fts_master_inst.cyc(1'h0, 1'h0, 1'h1, 6'h20, 4'hf, 3'h5, 1'h0, 36'h0);
        fts_master_inst.cyc(1'h0, 1'h0, 1'h1, 6'h20, 4'hf, SEL, 1'h0, 36'h0);
        chk_b(dq_oe, 1'h0, "read while asleep");
        fts_master_inst.cyc(1'h0, 1'h0, 1'h0, 6'h20, 4'h0, SEL, 1'h0, 36'h0);
        fts_master_inst.cyc(1'h0, 1'h1, 1'h0, 6'h20, 4'h0, 3'h5, 1'h1, 36'h0);
        chk_b(dq_oe, 1'h0, "write while asleep");
        sl = 1'h0;
        repeat (4)
            fts_master_inst.cyc(1'h0, 1'h0, 1'h1, 6'h20, 4'hf, 3'h5, 1'h0, 36'h0);
        go(1'h0, 1'h1, 6'h20, 4'hf, SEL, 36'h0);
        chk_b(wready, 1'h1, "commit room after wake");
        $display("t_sleep done");
    endtask : t_sleep

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        chk_b(dq_oe, 1'h0, "reset float");
        #1 rst_b = 1'h1;
        @(posedge clk);
        #1;
        chk_b(wready, 1'h1, "ready after reset");
        chk_b(dq_oe, 1'h0, "idle float");
        t_rw();
        t_oe();
        t_burst();
        t_sleep();
        report_and_stop();
    end

    // Hang guard
    initial begin
        #200000;
        n_fail++;
        $display("unexpected at %0t: timeout", $time);
        report_and_stop();
    end
endmodule : fts_sram_ctl_test
